//--- src/trace_port_consts.vh
// Constants for the processor trace port and its register block.
//
// Function
// RULE1 - Execute-valid flag is high exactly while execute holds a valid instruction.
// RULE2 - Output the 32-bit program counter of the execute-stage instruction.
// RULE3 - Flag register-file writes by the execute instruction and give the 5-bit index.
// RULE4 - Output the 32-bit value written to the destination register.
// RULE5 - Output a 10-bit status register snapshot from before the execute instruction.
// RULE6 - Pipeline-advance flag is high in cycles where the pipeline shifts.
// RULE7 - Interrupt-taken flag shows acceptance of an unmasked interrupt.
// RULE8 - Jump-taken flag is high when a branch condition evaluates true.
// RULE9 - Output the 4-bit prefetch slot feeding decode at the next shift.
// RULE10 - Stopped flag stays high while pipeline execution is halted.
// RULE11 - Branch flag is high when the instruction about to execute is a branch.
// RULE12 - Multi-cycle flag is high in every cycle of a multi-cycle instruction.
// RULE13 - Output the 32-bit data access address with a strobe marking it valid.
// RULE14 - Data-read flag is high when the data access is a read.
// RULE15 - Data-write flag is high when the data access is a write.
// RULE16 - Flag data addresses inside the data cache's cacheable range.
// RULE17 - Flag data addresses that hit in the data cache.
// RULE18 - Flag fetch addresses inside the instruction cache's cacheable range.
// RULE19 - Flag fetch addresses that hit in the instruction cache.
// RULE20 - Output the 32-bit instruction word now in execute.
// RULE21 - All trace outputs are registered on the processor clock.
`ifndef TRACE_PORT_CONSTS_VH
`define TRACE_PORT_CONSTS_VH

`define REG_IDX_W 4
`define IDX_CTRL 4'h0
`define IDX_STATUS 4'h1
`define IDX_IC_BASE 4'h2
`define IDX_IC_HIGH 4'h3
`define IDX_DC_BASE 4'h4
`define IDX_DC_HIGH 4'h5
`define IDX_INSTR_CNT 4'h6
`define IDX_IRQ_CNT 4'h7
`define IDX_BRANCH_CNT 4'h8
`define IDX_HALT_CNT 4'h9
`define IDX_LAST 4'h9

`define CTRL_IC_EN 0
`define CTRL_DC_EN 1
`define CTRL_CNT_EN 2
`define CTRL_W 3
`define CTRL_RESET 3'h7

`define STAT_HALTED 0
`define STAT_EX_VALID 1
`define STAT_ADVANCE 2

`define RANGE_BASE_RESET 32'h00000000
`define RANGE_HIGH_RESET 32'h03FFFFFF

`endif

//--- src/cache_range_check.v
// Cacheable-range and hit qualification for one cache side.
`timescale 1ns/10ps
`default_nettype none

module cache_range_check (
	input wire [31:0] addr,
	input wire addr_valid,
	input wire [31:0] base,
	input wire [31:0] high,
	input wire enable,
	input wire hit_raw,
	output wire in_range,
	output wire hit
);

	function in_window;
		input [31:0] a;
		input [31:0] lo;
		input [31:0] hi;
		begin
			in_window = (a >= lo) && (a <= hi);
		end
	endfunction

	// A disabled cache claims no range, so its raw hit is never trusted.
	assign in_range = enable & addr_valid & in_window(addr, base, high);
	assign hit = in_range & hit_raw;

endmodule

`default_nettype wire

//--- src/apb_reg_slave.v
// APB slave front end with one wait state and registered read data.
`timescale 1ns/10ps
`default_nettype none
`include "trace_port_consts.vh"

module apb_reg_slave (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	output wire pready,
	output wire pslverr,
	output wire [31:0] prdata,
	output wire [`REG_IDX_W-1:0] reg_idx,
	output wire reg_wr,
	input wire [31:0] rd_data
);

	reg pready_q;
	reg err_q;
	reg [31:0] prdata_q;
	wire mapped;

	assign reg_idx = paddr[`REG_IDX_W+1:2];
	assign mapped = ~|paddr[31:`REG_IDX_W+2] && (paddr[1:0] == 2'h0) &&
		(reg_idx <= `IDX_LAST);
	// Writes land only on the completing edge, as APB requires.
	assign reg_wr = psel & penable & pready_q & pwrite & mapped;
	assign pready = pready_q;
	assign pslverr = pready_q & err_q;
	assign prdata = prdata_q;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			err_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else begin
			pready_q <= psel & penable & ~pready_q;
			if (psel & penable & ~pready_q) begin
				err_q <= ~mapped;
				prdata_q <= (mapped & ~pwrite) ? rd_data : 32'h00000000;
			end
		end
	end

endmodule

`default_nettype wire

//--- src/processor_trace_port.v
// Trace port of the processor core with its APB control and statistics registers.
`timescale 1ns/10ps
`default_nettype none
`include "trace_port_consts.vh"

module processor_trace_port (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output wire pslverr,
	output wire [31:0] prdata,
	input wire core_ex_valid,
	input wire [31:0] core_ex_pc,
	input wire [31:0] core_ex_instr,
	input wire core_rf_we,
	input wire [4:0] core_rf_addr,
	input wire [31:0] core_rf_wdata,
	input wire [9:0] core_machine_status_register,
	input wire core_pipe_advance,
	input wire core_irq_accept,
	input wire core_is_branch,
	input wire core_branch_cond,
	input wire [3:0] core_prefetch_slot,
	input wire core_halted,
	input wire core_multicycle,
	input wire [31:0] core_daddr,
	input wire core_daddr_valid,
	input wire core_dread,
	input wire core_dwrite,
	input wire core_dcache_hit,
	input wire [31:0] core_iaddr,
	input wire core_iaddr_valid,
	input wire core_icache_hit,
	output reg exec_valid_flag,
	output reg [31:0] exec_program_counter,
	output reg [31:0] exec_instruction_word,
	output reg regfile_write_flag,
	output reg [4:0] regfile_write_index,
	output reg [31:0] regfile_write_value,
	output reg [9:0] machine_state_snapshot,
	output reg pipe_advance_flag,
	output reg irq_taken_flag,
	output reg jump_taken_flag,
	output reg branch_instr_flag,
	output reg [3:0] prefetch_slot,
	output reg core_stopped_flag,
	output reg multicycle_flag,
	output reg [31:0] dside_address,
	output reg dside_addr_strobe,
	output reg dside_read_flag,
	output reg dside_write_flag,
	output reg dcache_range_flag,
	output reg dcache_hit_flag,
	output reg icache_range_flag,
	output reg icache_hit_flag
);

	wire [`REG_IDX_W-1:0] reg_idx;
	wire reg_wr;
	reg [31:0] rd_data;

	reg [`CTRL_W-1:0] ctrl_q;
	reg [31:0] ic_base_q;
	reg [31:0] ic_high_q;
	reg [31:0] dc_base_q;
	reg [31:0] dc_high_q;
	reg [31:0] instr_cnt_q;
	reg [31:0] irq_cnt_q;
	reg [31:0] branch_cnt_q;
	reg [31:0] halt_cnt_q;
	reg [9:0] status_before_q;

	wire ic_in_range;
	wire ic_hit;
	wire dc_in_range;
	wire dc_hit;
	wire cnt_en;
	wire instr_done;
	wire jump_now;
	wire clr_instr;
	wire clr_irq;
	wire clr_branch;
	wire clr_halt;

	apb_reg_slave i_apb_reg_slave (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pready(pready),
		.pslverr(pslverr),
		.prdata(prdata),
		.reg_idx(reg_idx),
		.reg_wr(reg_wr),
		.rd_data(rd_data)
	);

	// The two caches are qualified alike; only their windows and enables differ.
	cache_range_check i_cache_range_check_ic (
		.addr(core_iaddr),
		.addr_valid(core_iaddr_valid),
		.base(ic_base_q),
		.high(ic_high_q),
		.enable(ctrl_q[`CTRL_IC_EN]),
		.hit_raw(core_icache_hit),
		.in_range(ic_in_range),
		.hit(ic_hit)
	);

	cache_range_check i_cache_range_check_dc (
		.addr(core_daddr),
		.addr_valid(core_daddr_valid),
		.base(dc_base_q),
		.high(dc_high_q),
		.enable(ctrl_q[`CTRL_DC_EN]),
		.hit_raw(core_dcache_hit),
		.in_range(dc_in_range),
		.hit(dc_hit)
	);

	assign cnt_en = ctrl_q[`CTRL_CNT_EN];
	assign instr_done = core_ex_valid & core_pipe_advance;
	assign jump_now = core_ex_valid & core_is_branch & core_branch_cond;

	// A counter cleared by software in the same cycle as an event restarts at one,
	// so no event is lost to the clear.
	function [31:0] count_next;
		input [31:0] cur;
		input clr;
		input inc;
		begin
			if (clr) begin
				count_next = inc ? 32'h00000001 : 32'h00000000;
			end else if (inc) begin
				count_next = cur + 32'h00000001;
			end else begin
				count_next = cur;
			end
		end
	endfunction

	// Software clears a counter by writing any value to its word.
	function wr_hits;
		input wr;
		input [`REG_IDX_W-1:0] idx;
		input [`REG_IDX_W-1:0] want;
		begin
			wr_hits = wr && (idx == want);
		end
	endfunction

	assign clr_instr = wr_hits(reg_wr, reg_idx, `IDX_INSTR_CNT);
	assign clr_irq = wr_hits(reg_wr, reg_idx, `IDX_IRQ_CNT);
	assign clr_branch = wr_hits(reg_wr, reg_idx, `IDX_BRANCH_CNT);
	assign clr_halt = wr_hits(reg_wr, reg_idx, `IDX_HALT_CNT);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `CTRL_RESET;
			ic_base_q <= `RANGE_BASE_RESET;
			ic_high_q <= `RANGE_HIGH_RESET;
			dc_base_q <= `RANGE_BASE_RESET;
			dc_high_q <= `RANGE_HIGH_RESET;
		end else if (reg_wr) begin
			case (reg_idx)
				`IDX_CTRL: begin
					ctrl_q <= pwdata[`CTRL_W-1:0];
				end
				`IDX_IC_BASE: begin
					ic_base_q <= pwdata;
				end
				`IDX_IC_HIGH: begin
					ic_high_q <= pwdata;
				end
				`IDX_DC_BASE: begin
					dc_base_q <= pwdata;
				end
				`IDX_DC_HIGH: begin
					dc_high_q <= pwdata;
				end
				default: begin
				end
			endcase
		end
	end

	// Counters wrap silently at the top of their range; software that needs long
	// runs must read them often enough.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr_cnt_q <= 32'h00000000;
		end else begin
			instr_cnt_q <= count_next(instr_cnt_q, clr_instr, cnt_en & instr_done);
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_cnt_q <= 32'h00000000;
		end else begin
			irq_cnt_q <= count_next(irq_cnt_q, clr_irq, cnt_en & core_irq_accept);
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			branch_cnt_q <= 32'h00000000;
		end else begin
			branch_cnt_q <= count_next(branch_cnt_q, clr_branch, cnt_en & jump_now);
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			halt_cnt_q <= 32'h00000000;
		end else begin
			halt_cnt_q <= count_next(halt_cnt_q, clr_halt, cnt_en & core_halted);
		end
	end

	always @* begin
		rd_data = 32'h00000000;
		case (reg_idx)
			`IDX_CTRL: begin
				rd_data[`CTRL_W-1:0] = ctrl_q;
			end
			`IDX_STATUS: begin
				rd_data[`STAT_HALTED] = core_stopped_flag;
				rd_data[`STAT_EX_VALID] = exec_valid_flag;
				rd_data[`STAT_ADVANCE] = pipe_advance_flag;
			end
			`IDX_IC_BASE: begin
				rd_data = ic_base_q;
			end
			`IDX_IC_HIGH: begin
				rd_data = ic_high_q;
			end
			`IDX_DC_BASE: begin
				rd_data = dc_base_q;
			end
			`IDX_DC_HIGH: begin
				rd_data = dc_high_q;
			end
			`IDX_INSTR_CNT: begin
				rd_data = instr_cnt_q;
			end
			`IDX_IRQ_CNT: begin
				rd_data = irq_cnt_q;
			end
			`IDX_BRANCH_CNT: begin
				rd_data = branch_cnt_q;
			end
			`IDX_HALT_CNT: begin
				rd_data = halt_cnt_q;
			end
			default: begin
				rd_data = 32'h00000000;
			end
		endcase
	end

	// The status word is caught as a new instruction enters execute, before that
	// instruction can change it.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_before_q <= 10'h000;
		end else if (core_pipe_advance) begin
			status_before_q <= core_machine_status_register; // [RULE5]
		end
	end

	// Every trace output is one flip-flop behind the core, so a single sample shows
	// one coherent execute-stage cycle; the snapshot is aligned by its own stage.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			exec_valid_flag <= 1'b0;
			exec_program_counter <= 32'h00000000;
			exec_instruction_word <= 32'h00000000;
			regfile_write_flag <= 1'b0;
			regfile_write_index <= 5'h00;
			regfile_write_value <= 32'h00000000;
			machine_state_snapshot <= 10'h000;
		end else begin // [RULE21]
			exec_valid_flag <= core_ex_valid; // [RULE1]
			exec_program_counter <= core_ex_pc; // [RULE2]
			exec_instruction_word <= core_ex_instr; // [RULE20]
			regfile_write_flag <= core_ex_valid & core_rf_we; // [RULE3]
			regfile_write_index <= core_rf_addr; // [RULE3]
			regfile_write_value <= core_rf_wdata; // [RULE4]
			machine_state_snapshot <= status_before_q; // [RULE5]
		end
	end

	// Pipeline and control-flow flags.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pipe_advance_flag <= 1'b0;
			irq_taken_flag <= 1'b0;
			jump_taken_flag <= 1'b0;
			branch_instr_flag <= 1'b0;
			prefetch_slot <= 4'h0;
			core_stopped_flag <= 1'b0;
			multicycle_flag <= 1'b0;
		end else begin // [RULE21]
			pipe_advance_flag <= core_pipe_advance; // [RULE6]
			irq_taken_flag <= core_irq_accept; // [RULE7]
			jump_taken_flag <= jump_now; // [RULE8]
			branch_instr_flag <= core_ex_valid & core_is_branch; // [RULE11]
			prefetch_slot <= core_prefetch_slot; // [RULE9]
			core_stopped_flag <= core_halted; // [RULE10]
			multicycle_flag <= core_multicycle; // [RULE12]
		end
	end

	// Data-side access and cache qualification flags.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dside_address <= 32'h00000000;
			dside_addr_strobe <= 1'b0;
			dside_read_flag <= 1'b0;
			dside_write_flag <= 1'b0;
			dcache_range_flag <= 1'b0;
			dcache_hit_flag <= 1'b0;
			icache_range_flag <= 1'b0;
			icache_hit_flag <= 1'b0;
		end else begin // [RULE21]
			dside_address <= core_daddr; // [RULE13]
			dside_addr_strobe <= core_daddr_valid; // [RULE13]
			dside_read_flag <= core_daddr_valid & core_dread; // [RULE14]
			dside_write_flag <= core_daddr_valid & core_dwrite; // [RULE15]
			dcache_range_flag <= dc_in_range; // [RULE16]
			dcache_hit_flag <= dc_hit; // [RULE17]
			icache_range_flag <= ic_in_range; // [RULE18]
			icache_hit_flag <= ic_hit; // [RULE19]
		end
	end

endmodule

`default_nettype wire

//--- verif/trace_port_asserts.sv
// Concurrent checks on the trace outputs and the register bus wait state.
`timescale 1ns/10ps
`default_nettype none
module trace_port_asserts (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic core_ex_valid,
	input wire logic [31:0] core_ex_pc,
	input wire logic core_rf_we,
	input wire logic [4:0] core_rf_addr,
	input wire logic [9:0] core_machine_status_register,
	input wire logic core_pipe_advance,
	input wire logic core_is_branch,
	input wire logic core_branch_cond,
	input wire logic core_halted,
	input wire logic core_daddr_valid,
	input wire logic core_dread,
	input wire logic exec_valid_flag,
	input wire logic [31:0] exec_program_counter,
	input wire logic regfile_write_flag,
	input wire logic [4:0] regfile_write_index,
	input wire logic [9:0] machine_state_snapshot,
	input wire logic jump_taken_flag,
	input wire logic branch_instr_flag,
	input wire logic core_stopped_flag,
	input wire logic dside_addr_strobe,
	input wire logic dside_read_flag,
	input wire logic dcache_range_flag,
	input wire logic dcache_hit_flag
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence apb_setup;
		psel && !penable;
	endsequence
	// A second advance would recapture, so only a lone advance fixes the snapshot.
	sequence lone_advance;
		core_pipe_advance ##1 !core_pipe_advance;
	endsequence
	a_valid_pc: assert property (1'b1 |=> exec_valid_flag == $past(core_ex_valid)
		&& exec_program_counter == $past(core_ex_pc)) else $error("execute trace lags");
	a_rf_write: assert property (core_ex_valid && core_rf_we |=> regfile_write_flag
		&& regfile_write_index == $past(core_rf_addr)) else $error("register write trace");
	a_snap_hold: assert property (lone_advance |=>
		machine_state_snapshot == $past(core_machine_status_register, 2))
		else $error("status snapshot");
	a_jump_branch: assert property (core_ex_valid && core_is_branch |=>
		branch_instr_flag && jump_taken_flag == $past(core_branch_cond)) else $error("branch");
	a_stop_rise: assert property ($rose(core_halted) |=> $rose(core_stopped_flag))
		else $error("stopped flag");
	a_dside_read: assert property (core_daddr_valid && core_dread |=>
		dside_addr_strobe && dside_read_flag) else $error("data read trace");
	a_dcache_hit: assert property (dcache_hit_flag |->
		dcache_range_flag && dside_addr_strobe) else $error("hit outside range");
	a_apb_wait: assert property (apb_setup |=> !pready ##1 pready)
		else $error("bus wait state");
endmodule
`default_nettype wire

//--- verif/trace_sampler.sv
// Model of the trace analysis logic: counts retired instructions.
`timescale 1ns/10ps
`default_nettype none
module trace_sampler (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic exec_valid_flag,
	input wire logic pipe_advance_flag,
	output var int retired
);
	// One sample per clock is enough because every trace output is a flop.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			retired <= 0;
		end else if (exec_valid_flag && pipe_advance_flag) begin
			retired <= retired + 1;
		end
	end
endmodule
`default_nettype wire

//--- verif/processor_trace_port_test.sv
// Self-checking bench: random core traffic and register access.
`timescale 1ns/10ps
`default_nettype none
`include "trace_port_consts.vh"
module processor_trace_port_test;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, den = 1, ien = 1;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, core_ex_pc = 32'h0, core_ex_instr = 32'h0;
	logic [31:0] core_rf_wdata = 32'h0, core_daddr = 32'h0, core_iaddr = 32'h0;
	logic [31:0] dlo = 32'h0, dhi = `RANGE_HIGH_RESET, ilo = 32'h0, ihi = `RANGE_HIGH_RESET;
	logic [32:0] flags = 33'h0;
	logic [9:0] snap = 10'h0;
	logic [65:0] exp_q[$];
	logic [32:0] bus_q[$];
	int due_q[$];
	int cyc = 0, mismatches = 0, n_checks = 0, retired, base;
	int n_irq = 0, n_jmp = 0, n_hlt = 0;
	logic cen = 1;
	logic [95:0] word_q[$];
	wire pready, pslverr, core_ex_valid, core_rf_we, core_pipe_advance, core_irq_accept;
	wire core_is_branch, core_branch_cond, core_halted, core_multicycle, core_daddr_valid;
	wire core_dread, core_dwrite, core_dcache_hit, core_iaddr_valid, core_icache_hit;
	wire [3:0] core_prefetch_slot, prefetch_slot;
	wire [4:0] core_rf_addr, regfile_write_index;
	wire [9:0] core_machine_status_register, machine_state_snapshot;
	wire [31:0] prdata, exec_program_counter, exec_instruction_word, regfile_write_value;
	wire [31:0] dside_address;
	wire exec_valid_flag, regfile_write_flag, pipe_advance_flag, irq_taken_flag;
	wire jump_taken_flag, branch_instr_flag, core_stopped_flag, multicycle_flag;
	wire dside_addr_strobe, dside_read_flag, dside_write_flag, dcache_range_flag;
	wire dcache_hit_flag, icache_range_flag, icache_hit_flag;
	assign {core_ex_valid, core_rf_we, core_pipe_advance, core_irq_accept, core_is_branch,
		core_branch_cond, core_halted, core_multicycle, core_daddr_valid, core_dread,
		core_dwrite, core_dcache_hit, core_iaddr_valid, core_icache_hit,
		core_prefetch_slot, core_rf_addr, core_machine_status_register} = flags;
	processor_trace_port i_processor_trace_port (.*);
	trace_sampler i_trace_sampler (.pclk(pclk), .presetn(presetn),
		.exec_valid_flag(exec_valid_flag), .pipe_advance_flag(pipe_advance_flag),
		.retired(retired));
	always #10 pclk = ~pclk;
	task check(input logic [65:0] seen, input logic [65:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [32:0] e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		bus_q.push_back(e);
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Boundary addresses of both ranges are hit on purpose: off by one is the likely slip.
	task drive(input int n);
		logic [63:0] r;
		logic [32:0] f;
		logic [31:0] d, i, ins;
		logic dcr, icr;
		repeat (n) begin
			@(posedge pclk);
			r = {$urandom, $urandom};
			ins = $urandom;
			f = r[32:0];
			d = r[33] ? dlo - 32'h1 + r[34] : dhi + r[34];
			i = r[35] ? ilo - 32'h1 + r[36] : ihi + r[36];
			dcr = den && f[24] && d >= dlo && d <= dhi;
			icr = ien && f[20] && i >= ilo && i <= ihi;
			flags <= f;
			core_daddr <= d;
			core_iaddr <= i;
			core_ex_instr <= ins;
			core_ex_pc <= r[63:32];
			core_rf_wdata <= ~r[63:32];
			exp_q.push_back({ins, snap, f[14:10], f[18:15], f[32], f[32] & f[31],
				f[32] & f[28] & f[27], f[32] & f[28], f[26], f[25], f[30], f[29], f[24],
				f[24] & f[23], f[24] & f[22], dcr, dcr & f[21], icr, icr & f[19]});
			due_q.push_back(cyc + 2);
			word_q.push_back({r[63:32], ~r[63:32], d});
			if (cen) begin
				n_irq += f[29];
				n_jmp += f[32] & f[28] & f[27];
				n_hlt += f[26];
			end
			if (f[30])
				snap = f[9:0];
		end
		@(posedge pclk);
		flags <= 33'h0;
		repeat (3) @(posedge pclk);
	endtask
	always @(negedge pclk) begin
		if (due_q.size() > 0 && due_q[0] <= cyc) begin
			void'(due_q.pop_front());
			check({exec_instruction_word, machine_state_snapshot, regfile_write_index,
				prefetch_slot, exec_valid_flag, regfile_write_flag, jump_taken_flag,
				branch_instr_flag, core_stopped_flag, multicycle_flag, pipe_advance_flag,
				irq_taken_flag, dside_addr_strobe, dside_read_flag, dside_write_flag,
				dcache_range_flag, dcache_hit_flag, icache_range_flag, icache_hit_flag},
				exp_q.pop_front());
			check({2'h0, exec_program_counter, regfile_write_value}, {2'h0, word_q[0][95:32]});
			check({34'h0, dside_address}, {34'h0, word_q[0][31:0]});
			void'(word_q.pop_front());
		end
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (psel && penable && pready === 1'b1)
			check({33'h0, pslverr, prdata}, {33'h0, bus_q.pop_front()});
		if (cyc == 20000) begin
			mismatches++;
			end_of_test();
		end
	end
	initial begin
		void'($urandom(94));
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 32'h00, 32'h0, {30'h0, `CTRL_RESET});
		apb(1'b0, 32'h0C, 32'h0, {1'b0, `RANGE_HIGH_RESET});
		apb(1'b0, 32'h10, 32'h0, 33'h0);
		apb(1'b1, 32'h04, 32'h7, 33'h0);
		apb(1'b0, 32'h04, 32'h0, 33'h0);
		apb(1'b0, 32'h28, 32'h0, 33'h1_0000_0000);
		apb(1'b1, 32'h02, 32'h5, 33'h1_0000_0000);
		$display("test registers done");
		drive(100);
		dlo = 32'h100;
		dhi = 32'h1FF;
		ilo = 32'h2000;
		ihi = 32'h2FFF;
		apb(1'b1, 32'h10, dlo, 33'h0);
		apb(1'b1, 32'h14, dhi, 33'h0);
		apb(1'b1, 32'h08, ilo, 33'h0);
		apb(1'b1, 32'h0C, ihi, 33'h0);
		drive(400);
		$display("test traffic done");
		base = retired;
		apb(1'b1, 32'h18, 32'h0, 33'h0);
		apb(1'b0, 32'h18, 32'h0, 33'h0);
		drive(200);
		apb(1'b0, 32'h18, 32'h0, {1'b0, 32'(retired - base)});
		$display("test counter done");
		apb(1'b1, 32'h00, 32'h4, 33'h0);
		den = 1'b0;
		ien = 1'b0;
		drive(100);
		$display("test cache off done");
		apb(1'b1, 32'h00, 32'h0, 33'h0);
		cen = 1'b0;
		drive(50);
		apb(1'b0, 32'h1C, 32'h0, {1'b0, 32'(n_irq)});
		apb(1'b0, 32'h20, 32'h0, {1'b0, 32'(n_jmp)});
		apb(1'b0, 32'h24, 32'h0, {1'b0, 32'(n_hlt)});
		$display("test counters off done");
		end_of_test();
	end
endmodule
bind processor_trace_port trace_port_asserts i_trace_port_asserts (.*);
`default_nettype wire
